// ===== logic/lbb_pkg.sv
// constants and types shared by the local bus bridge control block
`default_nettype none
package lbb_pkg;
    // host side register map
    localparam logic [7:0]  CTRL_OFS      = 8'h40;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [15:0] CTRL_WMASK    = 16'h0F7F;
    // control field positions
    localparam int          CLKE_BIT      = 0;
    localparam int          ARBE_BIT      = 1;
    localparam int          LEN_LSB       = 2;
    localparam int          WIDTH_BIT     = 6;
    localparam int          SEIZE_LSB     = 8;
    // widths
    localparam int          ADDR_W        = 20;
    localparam int          SEIZE_CNT_W   = 21;
    // cycle counts
    localparam logic [4:0]  TIMEOUT_PCLK  = 5'h10;
    localparam logic [20:0] SEIZE_BASE    = 21'h000020;
    localparam logic [20:0] SEIZE_GUARD   = 21'h000010;
    localparam logic [3:0]  LEN_BY_READY  = 4'h0;
    // host side sequencer, one-hot
    typedef enum logic [2:0] {
        H_IDLE  = 3'b001,
        H_WAIT  = 3'b010,
        H_DRAIN = 3'b100
    } lbb_host_st_e;
    // arbitration sequencer, one-hot
    typedef enum logic [2:0] {
        A_IDLE = 3'b001,
        A_REQ  = 3'b010,
        A_OWN  = 3'b100
    } lbb_arb_st_e;
    // byte lane decode result
    typedef struct packed {
        logic       valid;
        logic [1:0] a10;
        logic       bhe_n;
        logic       upper;
        logic [1:0] lanes;
        logic [1:0] lane;
    } lbb_lane_s;
endpackage
`default_nettype wire

// ===== logic/lbb_xfer_if.sv
// carrier between host side control and the local clock engine
`timescale 1ns/100ps
`default_nettype none
interface lbb_xfer_if;
    logic                      req_tgl;
    logic                      want_tgl;
    logic                      done_tgl;
    logic [lbb_pkg::ADDR_W-1:0] addr;
    logic [1:0]                lanes;
    logic                      bhe_n;
    logic                      write;
    logic [15:0]               wdata;
    logic [15:0]               rdata;
    logic                      room_ok;
    logic                      arb_en;
    logic [3:0]                len;
    logic [3:0]                seize;
    modport host (output req_tgl, want_tgl, addr, lanes, bhe_n, write, wdata,
                  arb_en, len, seize, input done_tgl, rdata, room_ok);
    modport engine (input req_tgl, want_tgl, addr, lanes, bhe_n, write, wdata,
                    arb_en, len, seize, output done_tgl, rdata, room_ok);
endinterface
`default_nettype wire

// ===== logic/lbb_local_engine.sv
// local clock domain: arbitration handshake, seize timer and bus cycles
`timescale 1ns/100ps
`default_nettype none
module lbb_local_engine (
    input  wire logic                       local_clock_in,
    input  wire logic                       rst_b_in,
    lbb_xfer_if.engine                      xf,
    input  wire logic                       bus_grant_n_in,
    input  wire logic                       local_ready_n_in,
    input  wire logic [15:0]                local_data_in,
    output logic                            bus_request_n_out,
    output logic                            grant_acknowledge_n_out,
    output logic [lbb_pkg::ADDR_W-1:0]      local_addr_out,
    output logic                            local_addr_oe_out,
    output logic [15:0]                     local_data_out,
    output logic [1:0]                      local_data_oe_out,
    output logic                            local_bhe_n_out,
    output logic                            local_wr_n_out,
    output logic                            local_rd_n_out
);
    import lbb_pkg::*;

    // hold count for a seize code: base doubled per step
    function automatic logic [SEIZE_CNT_W-1:0] seize_cycles(input logic [3:0] code);
        seize_cycles = SEIZE_BASE << code;
    endfunction

    logic [1:0]   rst_sync_r;
    logic [28:0]  s1_r;
    logic [28:0]  s2_r;
    logic         lrst_b;
    logic         req_seen_r;
    logic         want_seen_r;
    logic         pend_r;
    logic         busy_r;
    logic         done_r;
    logic [3:0]   cnt_r;
    logic [15:0]  rdata_r;
    logic [SEIZE_CNT_W-1:0] seize_r;
    lbb_arb_st_e  arb_r;
    logic         s_req, s_want, s_arb, s_gnt_n, s_rdy_n;
    logic [3:0]   s_len, s_seize;
    logic [15:0]  s_data;

    assign lrst_b = rst_sync_r[1];
    assign {s_req, s_want, s_arb, s_len, s_seize, s_gnt_n, s_rdy_n, s_data} = s2_r;
    assign xf.done_tgl = done_r;
    assign xf.rdata    = rdata_r;

    // reset and input synchronisers, two stages each
    always_ff @(posedge local_clock_in) begin
        rst_sync_r <= {rst_sync_r[0], rst_b_in};
        s1_r <= {xf.req_tgl, xf.want_tgl, xf.arb_en, xf.len, xf.seize,
                 bus_grant_n_in, local_ready_n_in, local_data_in};
        s2_r <= s1_r;
    end

    // arbitration: request, grant, hold for seize count, release
    always_ff @(posedge local_clock_in) begin
        if (!lrst_b) begin
            arb_r <= A_IDLE;
            pend_r <= 1'b0;
            want_seen_r <= 1'b0;
            seize_r <= '0;
            bus_request_n_out <= 1'b1;
            grant_acknowledge_n_out <= 1'b1;
            xf.room_ok <= 1'b0;
        end else begin
            want_seen_r <= s_want;
            if (s_want != want_seen_r) pend_r <= 1'b1;
            case (arb_r)
                A_IDLE: begin
                    if (s_arb && pend_r) begin
                        arb_r <= A_REQ;
                        bus_request_n_out <= 1'b0;
                    end
                end
                A_REQ: begin
                    if (!s_arb) begin
                        arb_r <= A_IDLE;
                        bus_request_n_out <= 1'b1;
                    end else if (!s_gnt_n) begin
                        arb_r <= A_OWN;
                        pend_r <= 1'b0;
                        bus_request_n_out <= 1'b1;
                        grant_acknowledge_n_out <= 1'b0;
                        seize_r <= seize_cycles(s_seize) - SEIZE_CNT_W'(1);
                    end
                end
                A_OWN: begin
                    if (s_arb && seize_r != '0) begin
                        seize_r <= seize_r - SEIZE_CNT_W'(1);
                    end else if (!busy_r) begin
                        arb_r <= A_IDLE;
                        grant_acknowledge_n_out <= 1'b1;
                    end
                end
                default: arb_r <= A_IDLE;
            endcase
            xf.room_ok <= (arb_r == A_OWN) && (seize_r >= SEIZE_GUARD);
        end
    end

    // one local bus cycle: fixed length or ended by ready
    always_ff @(posedge local_clock_in) begin
        if (!lrst_b) begin
            req_seen_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r <= 4'h0;
            rdata_r <= 16'h0000;
            local_addr_out <= '0;
            local_addr_oe_out <= 1'b0;
            local_data_out <= 16'h0000;
            local_data_oe_out <= 2'b00;
            local_bhe_n_out <= 1'b1;
            local_wr_n_out <= 1'b1;
            local_rd_n_out <= 1'b1;
        end else if (!busy_r) begin
            req_seen_r <= s_req;
            if (s_req != req_seen_r) begin
                busy_r <= 1'b1;
                cnt_r <= s_len;
                local_addr_out <= xf.addr;
                local_addr_oe_out <= 1'b1;
                local_bhe_n_out <= xf.bhe_n;
                local_data_out <= xf.wdata;
                local_data_oe_out <= xf.write ? xf.lanes : 2'b00;
                local_wr_n_out <= !xf.write;
                local_rd_n_out <= xf.write;
            end
        end else if ((cnt_r == LEN_BY_READY) ? !s_rdy_n : (cnt_r == 4'h1)) begin
            busy_r <= 1'b0;
            done_r <= !done_r;
            rdata_r <= s_data;
            local_addr_oe_out <= 1'b0;
            local_data_oe_out <= 2'b00;
            local_wr_n_out <= 1'b1;
            local_rd_n_out <= 1'b1;
        end else if (cnt_r != LEN_BY_READY) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule
`default_nettype wire

// ===== logic/lbb_bridge_top.sv
// local bus bridge control: host register, access checks, local engine
`timescale 1ns/100ps
`default_nettype none
module lbb_bridge_top (
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_b_in,
    input  wire logic                         local_clock_in,
    input  wire logic                         bridge_mode_in,
    input  wire logic                         soft_reset_in,
    // host register port
    input  wire logic                         host_cfg_wr_in,
    input  wire logic                         host_cfg_rd_in,
    input  wire logic [7:0]                   host_cfg_addr_in,
    input  wire logic [15:0]                  host_cfg_wdata_in,
    output logic      [15:0]                  host_cfg_rdata_out,
    // host local access port
    input  wire logic                         host_req_in,
    input  wire logic                         host_write_in,
    input  wire logic [lbb_pkg::ADDR_W-1:0]   host_addr_in,
    input  wire logic [3:0]                   host_byte_enable_n_in,
    input  wire logic [31:0]                  host_wdata_in,
    input  wire logic                         host_err_clr_in,
    output logic      [31:0]                  host_rdata_out,
    output logic                              host_done_out,
    output logic                              host_retry_out,
    output logic                              host_abort_out,
    output logic                              host_busy_out,
    output logic                              local_bus_error_flag_out,
    // local bus pins
    output logic                              local_clock_oe_out,
    input  wire logic                         bus_grant_n_in,
    input  wire logic                         local_ready_n_in,
    input  wire logic [15:0]                  local_data_in,
    output logic                              bus_request_n_out,
    output logic                              grant_acknowledge_n_out,
    output logic      [lbb_pkg::ADDR_W-1:0]   local_addr_out,
    output logic                              local_addr_oe_out,
    output logic      [15:0]                  local_data_out,
    output logic      [1:0]                   local_data_oe_out,
    output logic                              local_bhe_n_out,
    output logic                              local_wr_n_out,
    output logic                              local_rd_n_out
);
    import lbb_pkg::*;

    // ------------------------------------------------------------------
    // lane decode
    // ------------------------------------------------------------------

    // map active-low byte enables to address bits, lanes and high enable
    function automatic lbb_lane_s lane_decode(input logic [3:0] be_n,
                                              input logic       w8);
        lbb_lane_s d;
        logic [3:0] be;
        d = '0;
        be = ~be_n;
        d.bhe_n = 1'b1;
        d.lanes = 2'b01;
        // single lane index
        case (be)
            4'h1: d.lane = 2'h0;
            4'h2: d.lane = 2'h1;
            4'h4: d.lane = 2'h2;
            4'h8: d.lane = 2'h3;
            default: d.lane = 2'h0;
        endcase
        // lanes, then half-words
        if (be == 4'h1 || be == 4'h2 || be == 4'h4 || be == 4'h8) begin
            d.valid = 1'b1;
            d.a10 = d.lane;
            d.upper = d.lane[1];
            if (!w8 && d.lane[0]) begin
                d.bhe_n = 1'b0;
                d.lanes = 2'b10;
            end
        end else if (!w8 && (be == 4'h3 || be == 4'hC)) begin
            d.valid = 1'b1;
            d.upper = be[3];
            d.a10 = {be[3], 1'b0};
            d.bhe_n = 1'b0;
            d.lanes = 2'b11;
        end
        lane_decode = d;
    endfunction

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------

    // carrier
    lbb_xfer_if   xf ();
    logic [15:0]  ctrl_r;
    lbb_host_st_e host_r;
    logic [4:0]   tmo_r;
    logic [1:0]   ret_s1_r;
    logic [1:0]   ret_s2_r;
    logic         done_seen_r;
    logic         req_tgl_r;
    logic         want_tgl_r;
    logic [lbb_pkg::ADDR_W-1:0] addr_r;
    logic [1:0]   lanes_r;
    logic         bhe_n_r;
    logic         write_r;
    logic [15:0]  wdata_r;
    logic         w8_r;
    logic         done_new;
    logic         room_ok_s;
    logic         arb_en;
    logic         w8;
    logic         ctrl_hit;
    logic         err_set;
    lbb_lane_s    dec;

    // decode
    assign arb_en   = ctrl_r[ARBE_BIT];
    assign w8       = ctrl_r[WIDTH_BIT];
    assign ctrl_hit = bridge_mode_in && (host_cfg_addr_in == CTRL_OFS);
    assign dec      = lane_decode(host_byte_enable_n_in, w8);
    assign done_new = ret_s2_r[1] != done_seen_r;
    assign room_ok_s = ret_s2_r[0];

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------

    // only the pin reset clears it; soft reset is not wired here
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            ctrl_r <= CTRL_RESET;
        end else if (host_cfg_wr_in && ctrl_hit) begin
            ctrl_r <= host_cfg_wdata_in & CTRL_WMASK;
        end
    end

    // register read port, unmapped or config mode reads zero
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            host_cfg_rdata_out <= 16'h0000;
        end else if (host_cfg_rd_in) begin
            host_cfg_rdata_out <= ctrl_hit ? ctrl_r : 16'h0000;
        end
    end

    // local clock pad enable
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            local_clock_oe_out <= 1'b0;
        end else begin
            local_clock_oe_out <= ctrl_r[CLKE_BIT];
        end
    end

    // settings handed to the engine as quasi-static levels
    assign xf.arb_en = arb_en;
    assign xf.len    = ctrl_r[LEN_LSB +: 4];
    assign xf.seize  = ctrl_r[SEIZE_LSB +: 4];

    // ------------------------------------------------------------------
    // crossings back from the local clock domain
    // ------------------------------------------------------------------

    // done toggle and room level, two stages each
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            ret_s1_r <= 2'b00;
            ret_s2_r <= 2'b00;
            done_seen_r <= 1'b0;
        end else begin
            ret_s1_r <= {xf.done_tgl, xf.room_ok};
            ret_s2_r <= ret_s1_r;
            done_seen_r <= ret_s2_r[1];
        end
    end

    // ------------------------------------------------------------------
    // host access sequencer
    // ------------------------------------------------------------------

    // check, launch and time each host access to the local bus
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            host_r <= H_IDLE;
            tmo_r <= 5'h00;
            req_tgl_r <= 1'b0;
            want_tgl_r <= 1'b0;
            host_done_out <= 1'b0;
            host_retry_out <= 1'b0;
            host_abort_out <= 1'b0;
            host_busy_out <= 1'b0;
        end else begin
            host_done_out <= 1'b0;
            host_retry_out <= 1'b0;
            host_abort_out <= 1'b0;
            case (host_r)
                H_IDLE: begin
                    // one at a time
                    if (host_req_in && bridge_mode_in) begin
                        if (host_byte_enable_n_in == 4'hF) begin
                            host_done_out <= 1'b1;        // no lanes: nothing on the bus
                        end else if (!dec.valid) begin
                            host_abort_out <= 1'b1;
                        end else if (arb_en && !room_ok_s) begin
                            host_retry_out <= 1'b1;
                            want_tgl_r <= !want_tgl_r;
                        end else begin
                            req_tgl_r <= !req_tgl_r;
                            tmo_r <= 5'h00;
                            host_busy_out <= 1'b1;
                            host_r <= H_WAIT;
                        end
                    end
                end
                H_WAIT: begin
                    // done or timeout
                    if (done_new) begin
                        host_done_out <= 1'b1;
                        host_busy_out <= 1'b0;
                        host_r <= H_IDLE;
                    end else if (tmo_r == TIMEOUT_PCLK - 5'h01) begin
                        host_retry_out <= 1'b1;
                        host_r <= H_DRAIN;
                    end else begin
                        tmo_r <= tmo_r + 5'h01;
                    end
                end
                H_DRAIN: begin
                    // late cycle
                    if (done_new) begin                   // late cycle finished
                        host_busy_out <= 1'b0;
                        host_r <= H_IDLE;
                    end
                end
                default: host_r <= H_IDLE;
            endcase
        end
    end

    // request fields, held stable while the engine works
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            addr_r <= '0;
            lanes_r <= 2'b00;
            bhe_n_r <= 1'b1;
            write_r <= 1'b0;
            wdata_r <= 16'h0000;
            w8_r <= 1'b0;
        end else if (host_r == H_IDLE && host_req_in) begin
            addr_r <= {host_addr_in[ADDR_W-1:2], dec.a10};
            lanes_r <= dec.lanes;
            bhe_n_r <= dec.bhe_n;
            write_r <= host_write_in;
            w8_r <= w8;
            if (w8) begin
                wdata_r <= {8'h00, host_wdata_in[{dec.lane, 3'b000} +: 8]};
            end else begin
                wdata_r <= dec.upper ? host_wdata_in[31:16] : host_wdata_in[15:0];
            end
        end
    end

    // to engine
    assign xf.req_tgl  = req_tgl_r;
    assign xf.want_tgl = want_tgl_r;
    assign xf.addr     = addr_r;
    assign xf.lanes    = lanes_r;
    assign xf.bhe_n    = bhe_n_r;
    assign xf.write    = write_r;
    assign xf.wdata    = wdata_r;

    // read data spread over every lane it may belong to
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            host_rdata_out <= 32'h00000000;
        end else if (host_r == H_WAIT && done_new) begin
            host_rdata_out <= w8_r ? {4{xf.rdata[7:0]}} : {2{xf.rdata}};
        end
    end

    // ------------------------------------------------------------------
    // local bus error flag
    // ------------------------------------------------------------------

    // sticky; a timeout in the clearing cycle still sets it
    assign err_set = (host_r == H_WAIT) && !done_new && (tmo_r == TIMEOUT_PCLK - 5'h01);

    // set beats clear
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            local_bus_error_flag_out <= 1'b0;
        end else if (err_set) begin
            local_bus_error_flag_out <= 1'b1;
        end else if (host_err_clr_in || soft_reset_in) begin
            local_bus_error_flag_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // local clock engine
    // ------------------------------------------------------------------

    // local clock side
    lbb_local_engine u_engine (
        .local_clock_in                 (local_clock_in),
        .rst_b_in                (rst_b_in),
        .xf                      (xf.engine),
        .bus_grant_n_in          (bus_grant_n_in),
        .local_ready_n_in        (local_ready_n_in),
        .local_data_in           (local_data_in),
        .bus_request_n_out       (bus_request_n_out),
        .grant_acknowledge_n_out (grant_acknowledge_n_out),
        .local_addr_out          (local_addr_out),
        .local_addr_oe_out       (local_addr_oe_out),
        .local_data_out          (local_data_out),
        .local_data_oe_out       (local_data_oe_out),
        .local_bhe_n_out         (local_bhe_n_out),
        .local_wr_n_out          (local_wr_n_out),
        .local_rd_n_out          (local_rd_n_out)
    );
endmodule
`default_nettype wire

// ===== tb/lbb_checker.sv
// assertions on the bridge top ports
`timescale 1ns/100ps
`default_nettype none
module lbb_checker (
    input wire logic        ref_clk_in,
    input wire logic        rst_b_in,
    input wire logic        bridge_mode_in,
    input wire logic        host_cfg_rd_in,
    input wire logic [7:0]  host_cfg_addr_in,
    input wire logic [15:0] host_cfg_rdata_out,
    input wire logic        host_req_in,
    input wire logic [3:0]  host_byte_enable_n_in,
    input wire logic        host_busy_out,
    input wire logic        host_done_out,
    input wire logic        host_retry_out,
    input wire logic        host_abort_out,
    input wire logic        local_clock_oe_out,
    input wire logic        bus_request_n_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    wire logic go = host_req_in && !host_busy_out && bridge_mode_in;
    reset_state_a: assert property ($rose(rst_b_in) |-> host_cfg_rdata_out == 16'h0000
        && !local_clock_oe_out && bus_request_n_out) else $error("not in reset state");
    hidden_read_a: assert property (host_cfg_rd_in && (host_cfg_addr_in != 8'h40
        || !bridge_mode_in) |=> host_cfg_rdata_out == 16'h0000) else $error("read not zero");
    unused_bits_a: assert property (host_cfg_rdata_out[15:12] == 4'h0
        && !host_cfg_rdata_out[7]) else $error("unused bits set");
    no_lanes_a: assert property (go && host_byte_enable_n_in == 4'hF |=> host_done_out)
        else $error("no lane access not done");
    bad_lanes_a: assert property (go && host_byte_enable_n_in == 4'h5 |=> host_abort_out)
        else $error("bad lanes not aborted");
    abort_idle_a: assert property (host_abort_out |-> !host_busy_out)
        else $error("abort while busy");
    busy_bound_a: assert property ($rose(host_busy_out) |-> ##[0:16]
        (host_done_out || host_retry_out)) else $error("access not ended in time");
    retry_pulse_a: assert property (host_retry_out |=> !host_retry_out)
        else $error("retry longer than a cycle");
endmodule
bind lbb_bridge_top lbb_checker lbb_checker_i (.*);
`default_nettype wire

// ===== tb/lbb_arbiter_model.sv
// arbiter and peripheral on the local bus
`timescale 1ns/100ps
`default_nettype none
module lbb_arbiter_model (
    input  wire logic   local_clock_in,
    input  wire logic   slow_in,
    input  wire logic   bus_request_n_in,
    input  wire logic   local_rd_n_in,
    output logic        bus_grant_n_out = 1'h1,
    output logic        local_ready_n_out = 1'h1,
    output logic [15:0] local_data_out = 16'h0000
);
    logic [1:0] wait_r = 2'h0;
    // grant a request held two clocks, drop it with the request
    always @(posedge local_clock_in) begin
        wait_r <= bus_request_n_in ? 2'h0 : wait_r + {1'h0, wait_r != 2'h3};
        bus_grant_n_out <= bus_request_n_in || wait_r < 2'h2;
    end
    // ready after a clock unless stalling, data toggles when not read
    always @(posedge local_clock_in) begin
        local_ready_n_out <= local_rd_n_in || slow_in;
        local_data_out <= local_rd_n_in ? ~local_data_out : 16'hA55A;
    end
endmodule
`default_nettype wire

// ===== tb/test_local_bus_bridge_control.sv
// bench for the local bus bridge control block
`timescale 1ns/100ps
`default_nettype none
module test_local_bus_bridge_control;
    logic ref_clk_in = 1'h0, local_clock_in = 1'h0, rst_b_in = 1'h0, bridge_mode_in = 1'h1, slow = 1'h0;
    logic soft_reset_in = 1'h0, host_cfg_wr_in = 1'h0, host_cfg_rd_in = 1'h0, host_req_in = 1'h0;
    logic host_write_in = 1'h0, host_err_clr_in = 1'h0;
    logic [7:0] host_cfg_addr_in = 8'h40;
    logic [15:0] host_cfg_wdata_in = 16'h0000, host_cfg_rdata_out, local_data_in, local_data_out;
    logic [3:0] host_byte_enable_n_in = 4'hF;
    logic [19:0] host_addr_in = 20'h00000, local_addr_out;
    logic [31:0] host_wdata_in = 32'h00000000, host_rdata_out, sd = 32'h72BB1E29;
    logic [1:0] local_data_oe_out;
    logic [2:0] r;
    logic host_done_out, host_retry_out, host_abort_out, host_busy_out, local_bus_error_flag_out;
    logic local_clock_oe_out, bus_grant_n_in, local_ready_n_in, bus_request_n_out, local_rd_n_out;
    logic grant_acknowledge_n_out, local_addr_oe_out, local_bhe_n_out, local_wr_n_out;
    int err_count = 0, num_checks = 0, m = 0;
    // clocks
    always #20 ref_clk_in = ~ref_clk_in;
    always #80 local_clock_in = ~local_clock_in;
    lbb_bridge_top lbb_bridge_top_i (.*);
    lbb_arbiter_model lbb_arbiter_model_i (.local_clock_in(local_clock_in), .slow_in(slow),
        .bus_request_n_in(bus_request_n_out), .local_rd_n_in(local_rd_n_out),
        .bus_grant_n_out(bus_grant_n_in), .local_ready_n_out(local_ready_n_in),
        .local_data_out(local_data_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge ref_clk_in);
        host_cfg_wr_in <= 1'h1;
        host_cfg_wdata_in <= d;
        @(posedge ref_clk_in);
        host_cfg_wr_in <= 1'h0;
        if (bridge_mode_in) m = d & 16'h0F7F;
    endtask
    task automatic rd(input logic [7:0] a, input string s);
        @(posedge ref_clk_in);
        host_cfg_rd_in <= 1'h1;
        host_cfg_addr_in <= a;
        @(posedge ref_clk_in);
        host_cfg_rd_in <= 1'h0;
        host_cfg_addr_in <= 8'h40;
        @(posedge ref_clk_in);
        #1 chk(s, (a == 8'h40 && bridge_mode_in) ? m : 0, {16'h0000, host_cfg_rdata_out});
    endtask
    task automatic acc(input logic [3:0] be);
        @(posedge ref_clk_in);
        host_req_in <= 1'h1;
        host_err_clr_in <= 1'h1;
        host_byte_enable_n_in <= be;
        host_addr_in <= sd[19:0];
        sd = lfsr(sd);
        @(posedge ref_clk_in);
        host_req_in <= 1'h0;
        host_err_clr_in <= 1'h0;
        r = 3'h0;
        for (int i = 0; i < 60 && r == 3'h0; i++) begin
            #1 r = {host_abort_out, host_retry_out, host_done_out};
            if (r == 3'h0) @(posedge ref_clk_in);
        end
        slow = 1'h0;
        while (host_busy_out) #40;
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        #800000 err_count++;
        test_done;
    end
    // main sequence
    initial begin
        repeat (5) @(posedge local_clock_in);
        rst_b_in <= 1'h1;
        repeat (3) @(posedge local_clock_in);
        rd(8'h40, "ctrl reset");
        repeat (3) begin
            wr(sd[15:0] & 16'hFFDD);
            sd = lfsr(sd);
            rd(8'h40, "ctrl rw");
        end
        rd(8'h44, "unmapped");
        bridge_mode_in <= 1'h0;
        wr(16'h0001);
        rd(8'h40, "config mode");
        bridge_mode_in <= 1'h1;
        rd(8'h40, "bridge mode");
        soft_reset_in <= 1'h1;
        #40 soft_reset_in <= 1'h0;
        rd(8'h40, "soft reset");
        wr(16'h0041);
        #81 chk("clock enable", 1, local_clock_oe_out);
        acc(4'hF);
        chk("no lanes", 3'h1, r);
        acc(4'hC);
        chk("two lanes 8 bit", 3'h4, r);
        acc(4'h5);
        chk("bad lanes", 3'h4, r);
        acc(4'hB);
        chk("ready read", 4'h5, {r, local_bus_error_flag_out});
        slow = 1'h1;
        acc(4'hE);
        chk("timeout", 3'h2, {r[2:1], ~local_bus_error_flag_out});
        wr(16'h0002);
        acc(4'hC);
        chk("retry not granted", 5'h08, {r, local_addr_oe_out, local_bus_error_flag_out});
        for (int i = 0; i < 80 && grant_acknowledge_n_out; i++) #40;
        chk("granted", 2'h1, {grant_acknowledge_n_out, bus_request_n_out});
        repeat (8) @(posedge ref_clk_in);
        acc(4'hC);
        chk("owned access", 5'h0B, {r, local_bus_error_flag_out, bus_request_n_out});
        for (int i = 0; i < 200 && !grant_acknowledge_n_out; i++) #40;
        chk("released", 1, grant_acknowledge_n_out);
        test_done;
    end
endmodule
`default_nettype wire
